//--- hcs_regs.sv
// host configuration and status register bank
// How it works
// R1: any access with illegal byte enables after the address load sets the bad lane flag, bit 15.
// R2: flag clears only on host write of one to bit 15; reads current state.
// R3: the offending lane pattern is stored in bits 14 to 11, lane 3 highest.
// R4: host trusts the stored pattern only while the flag reads one.
// R5: endian strap is latched into configuration bit 10 at reset.
// R6: rom enable strap is latched into configuration bit 9 at reset.
// R7: bit 7 shows 8-bit bus mode, from rom or data-in strap.
// R8: bit 6 shows 16-bit bus mode, from rom or data-in strap.
// R9: bit 5 shows the 32-bit bonding option.
// R10: bit 3 shows the 128-pin package bonding option.
// R11: with rom fitted, three address words load from rom words 1 onward.
// R12: rom word 1 to low, word 2 to middle, word 3 to high register.
// R13: host address writes change only the registers, never the rom.
// R14: three 16-bit read/write address words, low word least significant.
// R15: bus control bit 6 picks pad drive, zero 8 mA, resets to zero.
// R16: bus control bit 2 picks clock source, zero base, one reserved.
// R17: bits 1-0 divide the bus clock by one, two, three; 11 reserved.
// R18: rom address load runs right after reset, before host operation.
// R19: illegal means unaligned for the bus width, or anything but lane 0 alone or lane 1 alone in 8-bit mode; first pattern kept until clear.
`include "hcs_map.svh"
`default_nettype none
module hcs_regs
  import hcs_pkg::*;
#(
  parameter logic BOND_BUS32  = 1'b0,
  parameter logic BOND_PKG128 = 1'b1
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // straps
  input  wire logic        endian_strap_pin,
  input  wire logic        rom_enable_strap_pin,
  input  wire logic        rom_data_in_pin,
  // rom word reader
  output logic             rom_rd_req,
  output logic [7:0]       rom_rd_addr,
  input  wire logic        rom_rd_ack,
  input  wire logic [15:0] rom_rd_data,
  input  wire logic        rom_bus8,
  input  wire logic        rom_bus16,
  // host register port
  input  wire logic        host_rd,
  input  wire logic        host_wr,
  input  wire logic [7:0]  host_addr,
  input  wire logic [3:0]  host_lanes,
  input  wire logic [15:0] host_wdata,
  output logic [15:0]      host_rdata,
  output logic             host_ready,
  // bank outputs
  output logic             drive_16ma,
  output logic             clk_src_sel,
  output logic [1:0]       clk_div_sel,
  output logic [47:0]      mac_address
);
  //////////////////////////////////////////////////////////////////////////////
  logic                  strap_done_q;
  logic                  endian_q;
  logic                  rom_present_q;
  logic                  bus8_q;
  logic                  bus16_q;
  logic                  flag_q;
  logic [3:0]            pattern_q;
  logic [15:0]           mac_q [3];
  logic [15:0]           bus_ctl_q;
  hcs_load_state_t       load_q;
  logic [1:0]            word_q;
  logic                  illegal;
  logic                  access;
  logic                  clear_flag;
  logic                  loading;

  assign access     = host_rd | host_wr;
  assign loading    = (load_q != HCS_LOAD_DONE);
  assign host_ready = ~loading; // [R18]

  hcs_lane_check u_lane_check
  (
    .lanes   (host_lanes),
    .bus8    (bus8_q),
    .bus16   (bus16_q),
    .bus32   (BOND_BUS32),
    .illegal (illegal)
  ); // [R19]

  //////////////////////////////////////////////////////////////////////////////
  // strap capture on the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      strap_done_q  <= 1'b0;
      endian_q      <= 1'b0;
      rom_present_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q  <= 1'b1;
      endian_q      <= endian_strap_pin;     // [R5]
      rom_present_q <= rom_enable_strap_pin; // [R6]
    end
  end

  // bus width bits: from rom when fitted, else from data-in strap
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bus8_q  <= 1'b0;
      bus16_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      bus8_q  <= rom_enable_strap_pin ? rom_bus8  : rom_data_in_pin;  // [R7]
      bus16_q <= rom_enable_strap_pin ? rom_bus16 : ~rom_data_in_pin; // [R8]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address load sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      load_q <= HCS_LOAD_IDLE;
      word_q <= 2'h0;
    end
    else
    begin
      unique case (load_q)
        HCS_LOAD_IDLE:
        begin
          if (strap_done_q)
          begin
            load_q <= rom_present_q ? HCS_LOAD_REQ : HCS_LOAD_DONE; // [R11] [R18]
          end
        end
        HCS_LOAD_REQ:
        begin
          load_q <= HCS_LOAD_WAIT;
        end
        HCS_LOAD_WAIT:
        begin
          if (rom_rd_ack)
          begin
            if (word_q == `HCS_ROM_MAC_WORDS - 2'h1)
            begin
              load_q <= HCS_LOAD_DONE;
            end
            else
            begin
              load_q <= HCS_LOAD_REQ;
            end
            word_q <= word_q + 2'h1;
          end
        end
        HCS_LOAD_DONE:
        begin
          load_q <= HCS_LOAD_DONE;
        end
      endcase
    end
  end

  assign rom_rd_req  = (load_q == HCS_LOAD_REQ);
  assign rom_rd_addr = `HCS_ROM_MAC_FIRST_WORD + {6'h00, word_q}; // [R11]

  //////////////////////////////////////////////////////////////////////////////
  // mac address words; no path ever writes back to the rom
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_mac
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          mac_q[gi] <= `HCS_RESET_MAC_WORD;
        end
        else if (load_q == HCS_LOAD_WAIT && rom_rd_ack && word_q == 2'(gi))
        begin
          mac_q[gi] <= rom_rd_data; // [R12]
        end
        else if (!loading && host_wr && !illegal
                 && host_addr == `HCS_OFS_MAC_ADDRESS_LOW + 8'(2 * gi))
        begin
          mac_q[gi] <= host_wdata; // [R13] [R14]
        end
      end
    end
  endgenerate

  assign mac_address = {mac_q[2], mac_q[1], mac_q[0]}; // [R14]

  //////////////////////////////////////////////////////////////////////////////
  // bad lane flag and pattern
  assign clear_flag = host_wr && !illegal && !loading
                      && host_addr == `HCS_OFS_BUS_ERROR_STATUS
                      && host_wdata[`HCS_BIT_BAD_LANE_FLAG];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      flag_q    <= 1'b0;
      pattern_q <= 4'h0;
    end
    else if (access && illegal && !loading)
    begin
      flag_q <= 1'b1; // [R1]
      if (!flag_q)
      begin
        pattern_q <= host_lanes; // [R3] [R19]
      end
    end
    else if (clear_flag)
    begin
      flag_q <= 1'b0; // [R2]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // internal bus control
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bus_ctl_q <= `HCS_RESET_BUS_CONTROL; // [R15] [R16] [R17]
    end
    else if (!loading && host_wr && !illegal
             && host_addr == `HCS_OFS_INTERNAL_BUS_CONTROL)
    begin
      bus_ctl_q <= host_wdata;
    end
  end

  assign drive_16ma  = bus_ctl_q[`HCS_BIT_DRIVE];   // [R15]
  assign clk_src_sel = bus_ctl_q[`HCS_BIT_CLK_SRC]; // [R16]
  assign clk_div_sel = bus_ctl_q[1:0];              // [R17]

  //////////////////////////////////////////////////////////////////////////////
  // read data, registered
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      host_rdata <= 16'h0000;
    end
    else if (host_rd && !loading)
    begin
      host_rdata <= 16'h0000;
      unique case (host_addr)
        `HCS_OFS_BUS_ERROR_STATUS:
        begin
          host_rdata[`HCS_BIT_BAD_LANE_FLAG] <= flag_q; // [R2] [R4]
          host_rdata[`HCS_BIT_PATTERN_HI:`HCS_BIT_PATTERN_LO] <= pattern_q;
        end
        `HCS_OFS_CHIP_CONFIGURATION:
        begin
          host_rdata[`HCS_BIT_ENDIAN]      <= endian_q;
          host_rdata[`HCS_BIT_ROM_PRESENT] <= rom_present_q;
          host_rdata[`HCS_BIT_BUS8]        <= bus8_q;
          host_rdata[`HCS_BIT_BUS16]       <= bus16_q;
          host_rdata[`HCS_BIT_BUS32]       <= BOND_BUS32;  // [R9]
          host_rdata[`HCS_BIT_PKG128]      <= BOND_PKG128; // [R10]
        end
        `HCS_OFS_MAC_ADDRESS_LOW:      host_rdata <= mac_q[0];
        `HCS_OFS_MAC_ADDRESS_MIDDLE:   host_rdata <= mac_q[1];
        `HCS_OFS_MAC_ADDRESS_HIGH:     host_rdata <= mac_q[2];
        `HCS_OFS_INTERNAL_BUS_CONTROL: host_rdata <= bus_ctl_q;
        default:                       host_rdata <= 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_flag_sets;
    @(posedge clk) disable iff (!rst_b)
    (access && illegal && !loading) |=> flag_q;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag not set"); // [R1]

  property p_flag_holds;
    @(posedge clk) disable iff (!rst_b)
    (flag_q && !clear_flag) |=> flag_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag lost"); // [R2]

  property p_pattern_kept;
    @(posedge clk) disable iff (!rst_b)
    flag_q |=> $stable(pattern_q);
  endproperty
  a_pattern_kept: assert property (p_pattern_kept) else $error("pattern moved"); // [R19]

  property p_pattern_cap;
    @(posedge clk) disable iff (!rst_b)
    (!flag_q && access && illegal && !loading) |=> pattern_q == $past(host_lanes);
  endproperty
  a_pattern_cap: assert property (p_pattern_cap) else $error("pattern wrong"); // [R3]

  property p_mac_write;
    @(posedge clk) disable iff (!rst_b)
    (!loading && host_wr && !illegal && host_addr == `HCS_OFS_MAC_ADDRESS_MIDDLE)
      |=> mac_q[1] == $past(host_wdata);
  endproperty
  a_mac_write: assert property (p_mac_write) else $error("mac write lost"); // [R14]

  // host writes are shut out until the address load is over
  property p_no_host_in_load;
    @(posedge clk) disable iff (!rst_b)
    loading |=> $stable(bus_ctl_q) && $stable(flag_q);
  endproperty
  a_no_host_in_load: assert property (p_no_host_in_load) else $error("ready early"); // [R18]

  property p_load_first;
    @(posedge clk) disable iff (!rst_b)
    (load_q == HCS_LOAD_IDLE && strap_done_q && rom_present_q)
      |=> rom_rd_req && rom_rd_addr == 8'h01;
  endproperty
  a_load_first: assert property (p_load_first) else $error("load start wrong"); // [R11]

  property p_load_fill;
    @(posedge clk) disable iff (!rst_b)
    (load_q == HCS_LOAD_WAIT && rom_rd_ack && word_q == 2'h2)
      |=> mac_q[2] == $past(rom_rd_data) && !loading;
  endproperty
  a_load_fill: assert property (p_load_fill) else $error("high word fill"); // [R12]

  property p_ctl_reset;
    @(posedge clk) $rose(rst_b) |-> !drive_16ma && !clk_src_sel && clk_div_sel == 2'b00;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("control reset"); // [R15]

  c_flag:  cover property (@(posedge clk) disable iff (!rst_b) $rose(flag_q));
  c_clear: cover property (@(posedge clk) disable iff (!rst_b) $fell(flag_q));
  c_load:  cover property (@(posedge clk) disable iff (!rst_b) $fell(loading));
  c_bus8:  cover property (@(posedge clk) disable iff (!rst_b) bus8_q && access && illegal);
endmodule
`default_nettype wire

//--- hcs_map.svh
// register offsets, field positions and reset values of the host configuration bank
`ifndef HCS_MAP_SVH
`define HCS_MAP_SVH

`define HCS_OFS_BUS_ERROR_STATUS      8'h06
`define HCS_OFS_CHIP_CONFIGURATION    8'h08
`define HCS_OFS_MAC_ADDRESS_LOW       8'h10
`define HCS_OFS_MAC_ADDRESS_MIDDLE    8'h12
`define HCS_OFS_MAC_ADDRESS_HIGH      8'h14
`define HCS_OFS_INTERNAL_BUS_CONTROL  8'h20

`define HCS_BIT_BAD_LANE_FLAG         15
`define HCS_BIT_PATTERN_HI            14
`define HCS_BIT_PATTERN_LO            11
`define HCS_BIT_ENDIAN                10
`define HCS_BIT_ROM_PRESENT           9
`define HCS_BIT_BUS8                  7
`define HCS_BIT_BUS16                 6
`define HCS_BIT_BUS32                 5
`define HCS_BIT_PKG128                3
`define HCS_BIT_DRIVE                 6
`define HCS_BIT_CLK_SRC               2

`define HCS_RESET_BUS_CONTROL         16'h0000
`define HCS_RESET_MAC_WORD            16'h0000
`define HCS_ROM_MAC_FIRST_WORD        8'h01
`define HCS_ROM_MAC_WORDS             2'h3

`endif

//--- hcs_pkg.sv
// types of the host configuration bank
`default_nettype none
package hcs_pkg;
  typedef enum logic [1:0]
  {
    HCS_LOAD_IDLE = 2'b00,
    HCS_LOAD_REQ  = 2'b01,
    HCS_LOAD_WAIT = 2'b10,
    HCS_LOAD_DONE = 2'b11
  } hcs_load_state_t;

  typedef enum logic [1:0]
  {
    HCS_DIV_BY1 = 2'b00,
    HCS_DIV_BY2 = 2'b01,
    HCS_DIV_BY3 = 2'b10,
    HCS_DIV_RSV = 2'b11
  } hcs_div_t;
endpackage
`default_nettype wire

//--- hcs_lane_check.sv
// byte-enable legality check for the configured host bus width
`default_nettype none
module hcs_lane_check
  import hcs_pkg::*;
(
  // lanes and width
  input  wire logic [3:0] lanes,
  input  wire logic       bus8,
  input  wire logic       bus16,
  input  wire logic       bus32,
  // verdict
  output logic            illegal
);
  logic ok;

  // only aligned byte, word or double-word lane sets are legal
  always_comb
  begin
    ok = 1'b0;
    unique case (lanes)
      4'h1, 4'h2, 4'h4, 4'h8: ok = 1'b1;
      4'h3, 4'hC:             ok = bus16 | bus32;
      4'hF:                   ok = bus32;
      default:                ok = 1'b0;
    endcase
    if (bus8 && lanes != 4'h1 && lanes != 4'h2)
    begin
      ok = 1'b0;
    end
  end

  assign illegal = ~ok;
endmodule
`default_nettype wire

//--- hcs_rom_model.sv
// word reader model that answers the station address load requests
`default_nettype none
module hcs_rom_model
  import hcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // word reader
  input  wire logic        rom_rd_req,
  input  wire logic [7:0]  rom_rd_addr,
  output logic             rom_rd_ack,
  output logic [15:0]      rom_rd_data,
  // observation
  output logic [7:0]       req_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] addr_q;
  logic [3:0] wait_q;
  logic       busy_q;

  function automatic logic [15:0] word(input logic [7:0] a);
    case (a)
      8'h01:   return 16'h89AB;
      8'h02:   return 16'h4567;
      8'h03:   return 16'h0123;
      default: return 16'hFFFF;
    endcase
  endfunction

  // latency grows with the word address, so answers come prompt and slow
  always_ff @(posedge clk)
  begin
    rom_rd_ack <= 1'b0;
    rom_rd_data <= ~rom_rd_data;
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      addr_q <= 8'h00;
      req_count <= 8'h00;
      rom_rd_data <= 16'h0000;
    end
    else if (rom_rd_req)
    begin
      busy_q <= 1'b1;
      addr_q <= rom_rd_addr;
      wait_q <= {rom_rd_addr[2:0], 1'b0};
      req_count <= req_count + 8'h01;
    end
    else if (busy_q && wait_q == 4'h0)
    begin
      busy_q <= 1'b0;
      rom_rd_ack <= 1'b1;
      rom_rd_data <= word(addr_q);
    end
    else if (busy_q)
    begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- host_config_status_registers_tb.sv
// self-checking testbench of the host configuration register bank
`default_nettype none
module host_config_status_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, endian, rom_en, din, bus8, bus16;
  logic        rreq, rack, host_rd, host_wr, ready, drv, csrc;
  logic [7:0]  raddr, host_addr, nreq;
  logic [15:0] rdat, host_wdata, host_rdata, v;
  logic [3:0]  host_lanes;
  logic [1:0]  cdiv;
  logic [47:0] mac;
  int          err_total, cmp_count, i;
  logic [15:0] bc [3] = '{16'h0041, 16'hFF82, 16'h0000};

  hcs_regs #(.BOND_BUS32(1'b0), .BOND_PKG128(1'b1)) uut (
    .clk(clk), .rst_b(rst_b), .endian_strap_pin(endian), .rom_enable_strap_pin(rom_en),
    .rom_data_in_pin(din), .rom_rd_req(rreq), .rom_rd_addr(raddr), .rom_rd_ack(rack),
    .rom_rd_data(rdat), .rom_bus8(bus8), .rom_bus16(bus16), .host_rd(host_rd),
    .host_wr(host_wr), .host_addr(host_addr), .host_lanes(host_lanes),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ready(ready),
    .drive_16ma(drv), .clk_src_sel(csrc), .clk_div_sel(cdiv), .mac_address(mac));

  hcs_rom_model rom (
    .clk(clk), .rst_b(rst_b), .rom_rd_req(rreq), .rom_rd_addr(raddr),
    .rom_rd_ack(rack), .rom_rd_data(rdat), .req_count(nreq));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [47:0] s, input logic [47:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task acc(input logic w, input logic [7:0] a, input logic [3:0] l, input logic [15:0] d);
    @(posedge clk);
    host_rd <= !w;
    host_wr <= w;
    host_addr <= a;
    host_lanes <= l;
    host_wdata <= d;
    @(posedge clk);
    host_rd <= 1'b0;
    host_wr <= 1'b0;
    #1;
    v = host_rdata;
  endtask

  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_boot;
    chk(ready, 1'b0);
    for (i = 0; i < 300 && ready !== 1'b1; i++)
      @(posedge clk);
    #1;
    chk(ready, 1'b1);
    chk(mac, 48'h0123_4567_89AB);
    chk(nreq, 8'h03);
    acc(0, 8'h08, 4'h3, 0);
    chk(v, 16'h0648);
    acc(1, 8'h08, 4'h3, 16'hFFFF);
    acc(0, 8'h08, 4'h3, 0);
    chk(v, 16'h0648);
    acc(0, 8'h10, 4'h3, 0);
    chk(v, 16'h89AB);
    $display("test boot done");
  endtask

  task t_mac;
    acc(1, 8'h10, 4'h3, 16'h1111);
    acc(1, 8'h12, 4'h3, 16'h2222);
    acc(1, 8'h14, 4'h3, 16'h3333);
    acc(0, 8'h14, 4'h3, 0);
    chk(v, 16'h3333);
    chk(mac, 48'h3333_2222_1111);
    chk(nreq, 8'h03);
    acc(0, 8'h0A, 4'h3, 0);
    chk(v, 16'h0000);
    $display("test mac done");
  endtask

  task t_err;
    acc(0, 8'h06, 4'h3, 0);
    chk(v, 16'h0000);
    acc(1, 8'h10, 4'hF, 16'hDEAD);
    acc(0, 8'h06, 4'h3, 0);
    chk(v, 16'hF800);
    acc(0, 8'h10, 4'h3, 0);
    chk(v, 16'h1111);
    acc(1, 8'h12, 4'h5, 16'h0000);
    acc(0, 8'h06, 4'h3, 0);
    chk(v, 16'hF800);
    acc(1, 8'h06, 4'h3, 16'h0000);
    acc(0, 8'h06, 4'h3, 0);
    chk(v, 16'hF800);
    acc(1, 8'h06, 4'h3, 16'h8000);
    acc(0, 8'h06, 4'h3, 0);
    chk(v[15], 1'b0);
    acc(1, 8'h14, 4'h6, 16'h0000);
    acc(0, 8'h06, 4'h3, 0);
    chk(v, 16'hB000);
    acc(1, 8'h06, 4'h3, 16'h8000);
    $display("test error done");
  endtask

  task t_bus;
    acc(0, 8'h20, 4'h3, 0);
    chk(v, 16'h0000);
    chk({drv, csrc, cdiv}, 4'h0);
    for (i = 0; i < 3; i++)
    begin
      acc(1, 8'h20, 4'h3, bc[i]);
      acc(0, 8'h20, 4'h3, 0);
      chk(v, bc[i]);
      chk({drv, csrc, cdiv}, {bc[i][6], bc[i][2], bc[i][1:0]});
    end
    $display("test bus control done");
  endtask

  task t_norom;
    acc(1, 8'h20, 4'h3, 16'h0041);
    @(posedge clk);
    rst_b <= 1'b0;
    {endian, rom_en, din} <= 3'b001;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(ready, 1'b0);
    @(posedge clk);
    #1;
    chk(ready, 1'b1);
    chk(nreq, 8'h00);
    chk(mac, 48'h0);
    chk({drv, csrc, cdiv}, 4'h0);
    acc(0, 8'h08, 4'h1, 0);
    chk(v, 16'h0088);
    acc(1, 8'h10, 4'h4, 16'h5555);
    acc(0, 8'h06, 4'h2, 0);
    chk(v, 16'hA000);
    acc(0, 8'h10, 4'h1, 0);
    chk(v, 16'h0000);
    acc(1, 8'h06, 4'h1, 16'h8000);
    acc(0, 8'h06, 4'h1, 0);
    chk(v[15], 1'b0);
    $display("test no rom done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test;
  end

  initial
  begin
    err_total = 0;
    cmp_count = 0;
    {rst_b, host_rd, host_wr, host_addr, host_lanes, host_wdata} = '0;
    {endian, rom_en, din, bus8, bus16} = 5'b11001;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    t_boot;
    t_mac;
    t_err;
    t_bus;
    t_norom;
    stop_test;
  end
endmodule
`default_nettype wire
